//--- sim/dbl_backlight_bench.sv
// display backlight control: self-checking bench against an integer model
// assumes dbl_partner drives keys and commands on falling edges
`timescale 1ns/1ps
module dbl_backlight_bench;
	import dbl_pkg::*;
	logic clk;
	logic rstn;
	logic [4:0] key_pin;
	logic [2:0] cmd;
	dbl_mode_t mode;
	dbl_mode_t shown_mode;
	logic [1:0] menu_entry;
	logic in_menu;
	logic in_submenu;
	logic backlight_en;
	int n_mismatch = 0;
	int n_compared = 0;
	int m_mode, m_shown, m_entry, m_menu, m_sub, m_lit;
	logic [31:0] seed = 32'h0000000F;
	logic [31:0] r;
	dbl_partner u_dbl_partner (.clk(clk), .key_pin(key_pin), .cmd(cmd));
	dbl_backlight u_dbl_backlight (.clk(clk), .rstn(rstn), .key_pin(key_pin),
		.light_off_cmd(cmd[0]), .light_on_cmd(cmd[1]), .light_timed_cmd(cmd[2]),
		.mode(mode), .shown_mode(shown_mode), .menu_entry(menu_entry),
		.in_menu(in_menu), .in_submenu(in_submenu), .backlight_en(backlight_en));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [3:0] got, input int exp);
		n_compared++;
		if (got !== 4'(exp)) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, 4'(exp));
		end
	endtask
	// entering auto starts dark: the hold timer is cleared outside auto
	function automatic void set_mode(input int n);
		if (n == 2 && m_mode != 2) m_lit = 0;
		m_mode = n;
	endfunction
	task automatic model_reset();
		m_mode = 2;
		m_shown = 2;
		m_entry = 0;
		m_menu = 0;
		m_sub = 0;
		m_lit = 0;
	endtask
	task automatic check_all();
		chk({2'h0, mode}, m_mode);
		chk({3'h0, in_menu}, m_menu);
		chk({3'h0, in_submenu}, m_sub);
		if (m_menu == 1 && m_sub == 0) chk({2'h0, menu_entry}, m_entry);
		if (m_sub == 1) chk({2'h0, shown_mode}, m_shown);
		chk({3'h0, backlight_en}, m_mode == 1 || (m_mode == 2 && m_lit == 1));
	endtask
	task automatic key(input int k);
		u_dbl_partner.press(k);
		if (m_mode == 2) m_lit = 1;
		if (k == 0 && m_menu == 0) begin
			m_menu = 1;
			m_entry = 0;
		end else if (k == 0 && m_sub == 0) m_entry = (m_entry + 1) % 4;
		else if (k == 1 && m_sub == 1) begin
			set_mode(m_shown);
			m_sub = 0;
			m_entry = 0;
		end else if (k == 1 && m_menu == 1 && m_entry == 3) begin
			m_sub = 1;
			m_shown = m_mode;
		end else if (k == 2 && m_sub == 1) m_shown = (m_shown + 1) % 3;
		else if (k == 3 && m_sub == 1) m_shown = (m_shown + 2) % 3;
		else if (k == 4) begin
			m_menu = 0;
			m_sub = 0;
		end
		check_all();
	endtask
	task automatic command(input logic [2:0] v);
		u_dbl_partner.send(v);
		if (v[0]) set_mode(0);
		else if (v[1]) set_mode(1);
		else if (v[2]) set_mode(2);
		check_all();
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ************
	// main sequence
	// ************
	initial begin
		rstn = 1'b0;
		model_reset();
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		check_all();
		chk({2'h0, shown_mode}, 2);
		key(2);
		repeat (500) @(negedge clk);
		check_all();
		command(3'h1);
		key(2);
		command(3'h2);
		command(3'h4);
		key(3);
		command(3'h7);
		command(3'h6);
		for (int i = 0; i < 9; i++) key(i == 5 ? 1 : 0);
		key(1);
		for (int i = 0; i < 8; i++) key(2 + i / 3 % 2);
		key(1);
		for (int i = 0; i < 5; i++) key(i == 4 ? 4 : (i == 3 ? 1 : 0));
		rstn = 1'b0;
		model_reset();
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		check_all();
		chk({2'h0, shown_mode}, 2);
		for (int i = 0; i < 60; i++) begin
			r = xs();
			if (r[0]) command(3'h1 << (r[2:1] % 3));
			else if (m_sub == 1 && r[5:3] % 5 == 0) key(4);
			else key(int'(r[5:3] % 5));
		end
		wrap_up();
	end
endmodule

//--- sim/dbl_partner.sv
// display backlight control: keypad and serial command source
// assumes the bench calls its tasks; clk is the design clock
`timescale 1ns/1ps
module dbl_partner (
	input wire logic clk,
	output logic [4:0] key_pin,
	output logic [2:0] cmd
);
	initial begin
		key_pin = 5'h00;
		cmd = 3'h0;
	end
	// one press, released before the next
	task automatic press(input int k);
		@(negedge clk) key_pin[k] = 1'b1;
		@(negedge clk) key_pin[k] = 1'b0;
		repeat (6) @(negedge clk);
	endtask
	// one-cycle command pulses: [0] off, [1] on, [2] timed
	task automatic send(input logic [2:0] v);
		@(negedge clk) cmd = v;
		@(negedge clk) cmd = 3'h0;
		repeat (2) @(negedge clk);
	endtask
endmodule

//--- src/dbl_backlight.sv
// display backlight control: mode register, setup submenu, auto timeout
// assumes serial commands are one-cycle pulses in clk domain, keys are raw pins
//
// How it works
// - mode off keeps backlight drive low regardless of keys.
// - mode on keeps backlight drive high continuously, no timeout.
// - auto: keypress lights, off after 30 s with no keypress.
// - three serial commands select off, on and auto; device applies them.
// - setup key steps menu entries; enter on light entry opens submenu.
// - up/down cycle candidate; enter commits and returns to menu top.
// - the single function key (key_pin[4]) leaves the setup menu.
`timescale 1ns/1ps
module dbl_backlight (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [4:0] key_pin,
	input wire logic light_off_cmd,
	input wire logic light_on_cmd,
	input wire logic light_timed_cmd,
	output dbl_pkg::dbl_mode_t mode,
	output dbl_pkg::dbl_mode_t shown_mode,
	output logic [1:0] menu_entry,
	output logic in_menu,
	output logic in_submenu,
	output logic backlight_en
);
	import dbl_pkg::*;

	typedef enum logic [1:0] {DBL_NORMAL, DBL_MENU, DBL_SUB} dbl_state_t;

	dbl_key_if keys ();
	dbl_state_t state;
	logic [DBL_CNT_W-1:0] hold_cnt;
	logic commit;

	dbl_key_sync u_keys (
		.clk(clk),
		.rstn(rstn),
		.key_pin(key_pin),
		.keys(keys)
	);

	// ************
	// setup menu walk
	// ************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= DBL_NORMAL;
			menu_entry <= DBL_MENU_SERIAL;
			shown_mode <= DBL_MODE_RESET;
		end else begin
			unique case (state)
				DBL_NORMAL: begin
					if (keys.setup_key) begin
						state <= DBL_MENU;
						menu_entry <= DBL_MENU_SERIAL;
					end
				end
				DBL_MENU: begin
					if (keys.func_key) begin
						state <= DBL_NORMAL;
					end else if (keys.setup_key) begin
						menu_entry <= menu_entry + 2'h1;
					end else if (keys.enter_key && menu_entry == DBL_MENU_LIGHT) begin
						state <= DBL_SUB;
						shown_mode <= mode;
					end
				end
				DBL_SUB: begin
					if (keys.func_key) begin
						state <= DBL_NORMAL;
					end else if (keys.enter_key) begin
						state <= DBL_MENU;
						menu_entry <= DBL_MENU_SERIAL;
					end else if (keys.up_key) begin
						shown_mode <= (shown_mode == DBL_MODE_AUTO) ? DBL_MODE_OFF :
							dbl_mode_t'(shown_mode + 2'h1);
					end else if (keys.down_key) begin
						shown_mode <= (shown_mode == DBL_MODE_OFF) ? DBL_MODE_AUTO :
							dbl_mode_t'(shown_mode - 2'h1);
					end
				end
				default: state <= DBL_NORMAL;
			endcase
		end
	end

	assign commit = (state == DBL_SUB) && keys.enter_key && !keys.func_key;
	assign in_menu = (state != DBL_NORMAL);
	assign in_submenu = (state == DBL_SUB);

	// ************
	// mode register
	// ************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode <= DBL_MODE_RESET;
		end else if (light_off_cmd) begin
			mode <= DBL_MODE_OFF;
		end else if (light_on_cmd) begin
			mode <= DBL_MODE_ON;
		end else if (light_timed_cmd) begin
			mode <= DBL_MODE_AUTO;
		end else if (commit) begin
			mode <= shown_mode;
		end
	end

	// ************
	// auto timeout and drive
	// ************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hold_cnt <= '0;
		end else if (mode != DBL_MODE_AUTO) begin
			hold_cnt <= '0;
		end else if (keys.any_key) begin
			hold_cnt <= DBL_CNT_W'(DBL_HOLD_CYCLES);
		end else if (hold_cnt != '0) begin
			hold_cnt <= hold_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			backlight_en <= 1'b0;
		end else begin
			unique case (mode)
				DBL_MODE_OFF: backlight_en <= 1'b0;
				DBL_MODE_ON: backlight_en <= 1'b1;
				DBL_MODE_AUTO: backlight_en <= keys.any_key || (hold_cnt > DBL_CNT_W'(1));
				default: backlight_en <= 1'b0;
			endcase
		end
	end

	// ************
	// checks
	// ************
	a_off_dark: assert property (@(posedge clk) disable iff (!rstn)
		$past(mode) == DBL_MODE_OFF && mode == DBL_MODE_OFF |=> !backlight_en)
		else $error("backlight lit in off mode");
	a_on_lit: assert property (@(posedge clk) disable iff (!rstn)
		mode == DBL_MODE_ON |=> backlight_en)
		else $error("backlight dark in on mode");
	a_auto_press: assert property (@(posedge clk) disable iff (!rstn)
		mode == DBL_MODE_AUTO && keys.any_key |=> backlight_en)
		else $error("keypress did not light backlight");
	a_auto_reload: assert property (@(posedge clk) disable iff (!rstn)
		mode == DBL_MODE_AUTO && keys.any_key |=> hold_cnt == DBL_CNT_W'(DBL_HOLD_CYCLES))
		else $error("hold timer not reloaded");
	a_auto_expire: assert property (@(posedge clk) disable iff (!rstn)
		mode == DBL_MODE_AUTO && hold_cnt <= DBL_CNT_W'(1) && !keys.any_key |=> !backlight_en)
		else $error("backlight lit after timeout");
	a_cmd_off: assert property (@(posedge clk) disable iff (!rstn)
		light_off_cmd |=> mode == DBL_MODE_OFF)
		else $error("off command ignored");
	a_cmd_timed: assert property (@(posedge clk) disable iff (!rstn)
		light_timed_cmd && !light_off_cmd && !light_on_cmd |=> mode == DBL_MODE_AUTO)
		else $error("auto command ignored");
	sequence s_open;
		state == DBL_MENU && menu_entry == DBL_MENU_LIGHT && keys.enter_key && !keys.func_key
			&& !keys.setup_key;
	endsequence
	a_sub_open: assert property (@(posedge clk) disable iff (!rstn)
		s_open |=> in_submenu && shown_mode == $past(mode))
		else $error("submenu did not open with current mode");
	a_sub_commit: assert property (@(posedge clk) disable iff (!rstn)
		commit && !light_off_cmd && !light_on_cmd && !light_timed_cmd
			|=> mode == $past(shown_mode) && state == DBL_MENU && menu_entry == DBL_MENU_SERIAL)
		else $error("commit failed");
	a_func_exit: assert property (@(posedge clk) disable iff (!rstn)
		in_menu && keys.func_key |=> !in_menu)
		else $error("function key did not leave menu");
	a_mode_hold: assert property (@(posedge clk) disable iff (!rstn)
		!light_off_cmd && !light_on_cmd && !light_timed_cmd && !commit |=> $stable(mode))
		else $error("mode changed without cause");

	// ************
	// on command, off-mode keypress, menu steps and hold timer
	// ************
	sequence s_step_up;
		state == DBL_SUB && keys.up_key && !keys.enter_key && !keys.func_key;
	endsequence
	sequence s_step_down;
		state == DBL_SUB && keys.down_key && !keys.up_key && !keys.enter_key && !keys.func_key;
	endsequence
	a_cmd_on: assert property (@(posedge clk) disable iff (!rstn)
		light_on_cmd && !light_off_cmd |=> mode == DBL_MODE_ON)
		else $error("on command ignored");
	a_off_press: assert property (@(posedge clk) disable iff (!rstn)
		mode == DBL_MODE_OFF && keys.any_key |=> !backlight_en)
		else $error("keypress lit backlight in off mode");
	a_menu_enter: assert property (@(posedge clk) disable iff (!rstn)
		state == DBL_NORMAL && keys.setup_key |=> in_menu && menu_entry == DBL_MENU_SERIAL)
		else $error("setup key did not open menu at first entry");
	a_menu_idle: assert property (@(posedge clk) disable iff (!rstn)
		state == DBL_NORMAL && !keys.setup_key |=> !in_menu)
		else $error("menu opened without setup key");
	a_entry_step: assert property (@(posedge clk) disable iff (!rstn)
		state == DBL_MENU && keys.setup_key && !keys.func_key
			|=> in_menu && menu_entry == $past(menu_entry) + 2'h1)
		else $error("setup key did not step menu entry");
	a_enter_ignore: assert property (@(posedge clk) disable iff (!rstn)
		state == DBL_MENU && keys.enter_key && menu_entry != DBL_MENU_LIGHT
			&& !keys.func_key && !keys.setup_key |=> in_menu && !in_submenu)
		else $error("enter opened submenu on wrong entry");
	a_up_wrap: assert property (@(posedge clk) disable iff (!rstn)
		(s_step_up ##0 shown_mode == DBL_MODE_AUTO) |=> shown_mode == DBL_MODE_OFF)
		else $error("up key did not wrap to off");
	a_down_wrap: assert property (@(posedge clk) disable iff (!rstn)
		(s_step_down ##0 shown_mode == DBL_MODE_OFF) |=> shown_mode == DBL_MODE_AUTO)
		else $error("down key did not wrap to auto");
	a_func_keep: assert property (@(posedge clk) disable iff (!rstn)
		state == DBL_SUB && keys.func_key && !light_off_cmd && !light_on_cmd
			&& !light_timed_cmd |=> !in_menu && $stable(mode))
		else $error("function key in submenu changed mode");
	a_auto_hold: assert property (@(posedge clk) disable iff (!rstn)
		mode == DBL_MODE_AUTO && hold_cnt > DBL_CNT_W'(1) |=> backlight_en)
		else $error("backlight dark before timeout");
	a_auto_count: assert property (@(posedge clk) disable iff (!rstn)
		mode == DBL_MODE_AUTO && !keys.any_key && hold_cnt != '0
			|=> hold_cnt == $past(hold_cnt) - 1'b1)
		else $error("hold timer did not count down");
	a_leave_clear: assert property (@(posedge clk) disable iff (!rstn)
		mode != DBL_MODE_AUTO |=> hold_cnt == '0)
		else $error("hold timer kept outside auto");
endmodule

//--- src/dbl_key_if.sv
// display backlight control: key event bundle between top and key front end
// assumes one clock; events are one-cycle pulses
`timescale 1ns/1ps
interface dbl_key_if;
	logic any_key;
	logic setup_key;
	logic enter_key;
	logic up_key;
	logic down_key;
	logic func_key;

	modport src (
		output any_key,
		output setup_key,
		output enter_key,
		output up_key,
		output down_key,
		output func_key
	);
	modport dst (
		input any_key,
		input setup_key,
		input enter_key,
		input up_key,
		input down_key,
		input func_key
	);
endinterface

//--- src/dbl_key_sync.sv
// display backlight control: key pin synchroniser and press detector
// assumes raw active-high debounced key levels from the front panel
`timescale 1ns/1ps
module dbl_key_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [4:0] key_pin,
	dbl_key_if.src keys
);
	logic [4:0] meta;
	logic [4:0] sync;
	logic [4:0] last;
	logic [4:0] press;

	// ************
	// two-stage synchroniser, then rising edge
	// ************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= 5'h00;
			sync <= 5'h00;
			last <= 5'h00;
		end else begin
			meta <= key_pin;
			sync <= meta;
			last <= sync;
		end
	end

	assign press = sync & ~last;
	assign keys.setup_key = press[0];
	assign keys.enter_key = press[1];
	assign keys.up_key = press[2];
	assign keys.down_key = press[3];
	assign keys.func_key = press[4];
	assign keys.any_key = |press;
endmodule

//--- src/dbl_pkg.sv
// display backlight control: shared constants and types
// assumes a single 100 MHz clock domain
package dbl_pkg;
	// ************
	// backlight modes
	// ************
	typedef enum logic [1:0] {
		DBL_MODE_OFF = 2'h0,
		DBL_MODE_ON = 2'h1,
		DBL_MODE_AUTO = 2'h2
	} dbl_mode_t;

	localparam dbl_mode_t DBL_MODE_RESET = DBL_MODE_AUTO;

	// ************
	// timing
	// ************
	localparam int unsigned DBL_CLK_HZ = 100_000_000;
	localparam int unsigned DBL_HOLD_S = 30;
	localparam longint unsigned DBL_HOLD_CYCLES = longint'(DBL_HOLD_S) * longint'(DBL_CLK_HZ);
	localparam int DBL_CNT_W = 32;

	// ************
	// setup menu entries
	// ************
	localparam int DBL_MENU_ENTRIES = 4;
	localparam logic [1:0] DBL_MENU_SERIAL = 2'h0;
	localparam logic [1:0] DBL_MENU_LIGHT = 2'h3;
endpackage
